// *** rtl/host_port_cfg.svh ***
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
// Overview of operation
// RQ1: Single strobe: data strobe plus select transfers
// RQ2: Dual strobe: shared strobe is write strobe
// RQ3: No transfer without chip select asserted
// RQ4: Mode 0: one open-drain service request
// RQ5: Mode 1: request pin is transmit request
// RQ6: Mode 1: acknowledge pin is receive request
// RQ7: Mode 0: host drives acknowledge for DMA
// RQ8: Mode 0: acknowledge also interrupt acknowledge handshake
// RQ9: Reset disconnects pins, ignores inputs, releases requests
// RQ10: Unselected port: pins are individual GPIO bits
// RQ11: Single strobe: direction input selects read/write
// RQ12: Dual strobe: direction pin is read strobe
// RQ13: Requests active low, pulled low to assert
`define HP_MODE_SINGLE 1'b0
`define HP_MODE_DUAL 1'b1
`define HP_REQ_MODE0 1'b0
`define HP_REQ_MODE1 1'b1
`define HP_OD_ASSERT 1'b0
`define HP_OD_RELEASE 1'b1
`define HP_PIN_COUNT 5
`define HP_PIN_DS 0
`define HP_PIN_CS 1
`define HP_PIN_REQ 2
`define HP_PIN_ACK 3
`define HP_PIN_RW 4
`define HP_GPIO_RESET 5'h00
`endif

// *** rtl/host_port_pkg.sv ***
package host_port_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_DONE = 2'b11
  } access_state_type;
  typedef enum logic [1:0]
  {
    ACC_NONE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10,
    ACC_IACK = 2'b11
  } access_kind_type;
endpackage

// *** rtl/host_port_if.sv ***
`timescale 1ns/100ps
interface host_port_if;
  // Pins of the shared port; the device end drives with an enable, the host end drives always, the testbench resolves the wire
  logic host_data_strobe;
  logic host_port_select;
  logic host_read_write_dir;
  logic host_acknowledge_in;
  logic req_pin_out;
  logic req_pin_oe;
  logic ack_pin_out;
  logic ack_pin_oe;
  logic [4:0] gpio_dev_out;
  logic [4:0] gpio_dev_oe;
  logic [4:0] pin_level;
  modport device
  (
    input pin_level,
    output req_pin_out, req_pin_oe, ack_pin_out, ack_pin_oe, gpio_dev_out, gpio_dev_oe
  );
  modport host
  (
    input pin_level,
    output host_data_strobe, host_port_select, host_read_write_dir, host_acknowledge_in
  );
endinterface

// *** rtl/host_port_device.sv ***
`timescale 1ns/100ps
`include "host_port_cfg.svh"
module host_port_device
(
  input wire logic I_CLK, // 40 MHz clock
  input wire logic I_RESET_N, // Async reset, active low
  input wire logic I_CE, // Clock enable
  host_port_if.device BUS, // Pin side
  input wire logic I_PORT_SEL, // Host port function selected
  input wire logic I_BUS_MODE, // 0 single strobe, 1 dual strobe
  input wire logic I_REQ_MODE, // Request mode select
  input wire logic I_TX_REQ, // Core wants transmit service
  input wire logic I_RX_REQ, // Core wants receive service
  input wire logic [4:0] I_GPIO_OUT, // GPIO output values
  input wire logic [4:0] I_GPIO_DIR, // GPIO direction, 1 drives
  output logic [4:0] O_GPIO_IN, // GPIO sampled levels
  output logic O_RD_PULSE, // Host read taken
  output logic O_WR_PULSE, // Host write taken
  output logic O_IACK_PULSE // Host acknowledge taken
);
  import host_port_pkg::*;
  logic active_q;
  logic [4:0] pin_q;
  logic [4:0] gpio_in_q;
  logic strobe_q;
  logic rd_q, wr_q, iack_q, ack_q;
  logic req_oe_q, ackp_oe_q;
  logic [4:0] gpio_out_q, gpio_oe_q;
  wire logic hp_on;
  wire logic cs_n, ds_n, rw_n, ack_n;
  wire logic strobe_now, strobe_rise;
  wire logic is_read, is_write;
  wire logic ack_now, ack_rise;
  wire logic req_any;
  // Active only after reset release; keeps pins isolated in the first cycle too
  assign hp_on = active_q && I_PORT_SEL; // RQ9 RQ10
  assign cs_n = pin_q[`HP_PIN_CS];
  assign ds_n = pin_q[`HP_PIN_DS];
  assign rw_n = pin_q[`HP_PIN_RW];
  assign ack_n = pin_q[`HP_PIN_ACK];
  // Strobes count only with select low; dual mode ORs read and write strobes
  assign strobe_now = hp_on && !cs_n && (I_BUS_MODE == `HP_MODE_SINGLE ? !ds_n : (!ds_n || !rw_n)); // RQ1 RQ2 RQ3
  assign strobe_rise = strobe_now && !strobe_q;
  assign is_read = I_BUS_MODE == `HP_MODE_SINGLE ? rw_n : !rw_n; // RQ11 RQ12
  assign is_write = I_BUS_MODE == `HP_MODE_SINGLE ? !rw_n : !ds_n; // RQ2 RQ11
  // Acknowledge is an input only in mode 0; select need not be low for it
  assign ack_now = hp_on && I_REQ_MODE == `HP_REQ_MODE0 && !ack_n; // RQ7 RQ8
  assign ack_rise = ack_now && !ack_q;
  assign req_any = I_REQ_MODE == `HP_REQ_MODE0 ? (I_TX_REQ || I_RX_REQ) : I_TX_REQ; // RQ4 RQ5
  // Pins sampled as synchronous inputs
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      active_q <= 1'b0;
      pin_q <= `HP_GPIO_RESET;
    end
    else if (I_CE)
    begin
      active_q <= 1'b1;
      pin_q <= BUS.pin_level;
    end
  end
  // Access detection on strobe and acknowledge edges
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      strobe_q <= 1'b0;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      iack_q <= 1'b0;
    end
    else if (I_CE)
    begin
      strobe_q <= strobe_now;
      ack_q <= ack_now;
      rd_q <= strobe_rise && is_read; // RQ1 RQ12
      wr_q <= strobe_rise && is_write && !is_read; // RQ2 RQ11
      iack_q <= ack_rise; // RQ8
    end
  end
  // Open-drain requests: only ever drive low, release otherwise
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      req_oe_q <= 1'b0; // RQ9
      ackp_oe_q <= 1'b0; // RQ9
    end
    else if (I_CE)
    begin
      req_oe_q <= hp_on && req_any; // RQ4 RQ5 RQ13
      ackp_oe_q <= hp_on && I_REQ_MODE == `HP_REQ_MODE1 && I_RX_REQ; // RQ6 RQ13
    end
  end
  // GPIO path when the host function is off
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      gpio_out_q <= `HP_GPIO_RESET;
      gpio_oe_q <= `HP_GPIO_RESET;
      gpio_in_q <= `HP_GPIO_RESET;
    end
    else if (I_CE)
    begin
      gpio_out_q <= I_GPIO_OUT;
      gpio_oe_q <= (active_q && !I_PORT_SEL) ? I_GPIO_DIR : `HP_GPIO_RESET; // RQ10
      gpio_in_q <= (active_q && !I_PORT_SEL) ? pin_q : `HP_GPIO_RESET; // RQ9 RQ10
    end
  end
  assign BUS.req_pin_out = `HP_OD_ASSERT; // RQ13
  assign BUS.req_pin_oe = req_oe_q;
  assign BUS.ack_pin_out = `HP_OD_ASSERT; // RQ13
  assign BUS.ack_pin_oe = ackp_oe_q;
  assign BUS.gpio_dev_out = gpio_out_q;
  assign BUS.gpio_dev_oe = gpio_oe_q;
  assign O_GPIO_IN = gpio_in_q;
  assign O_RD_PULSE = rd_q;
  assign O_WR_PULSE = wr_q;
  assign O_IACK_PULSE = iack_q;
endmodule

// *** rtl/host_port_host.sv ***
`timescale 1ns/100ps
`include "host_port_cfg.svh"
module host_port_host
(
  input wire logic I_CLK, // 40 MHz clock
  input wire logic I_RESET_N, // Async reset, active low
  input wire logic I_CE, // Clock enable
  host_port_if.host BUS, // Pin side
  input wire logic I_BUS_MODE, // 0 single strobe, 1 dual strobe
  input wire logic I_REQ_MODE, // Request mode select
  input wire logic I_START, // Start an access
  input wire host_port_pkg::access_kind_type I_KIND, // Kind of access
  output logic O_BUSY, // Access in progress
  output logic O_SERVICE_REQ, // Request line seen low
  output logic O_RX_REQ // Receive request seen low, mode 1
);
  import host_port_pkg::*;
  access_state_type state_q, state_d;
  access_kind_type kind_q;
  logic ds_q, cs_q, rw_q, ack_q;
  logic srv_q, rx_q, busy_q;
  access_kind_type cur_kind;
  wire logic take;
  wire logic drive;
  assign take = state_q == ST_IDLE && I_START && I_KIND != ACC_NONE;
  assign drive = state_d == ST_ACCESS;
  // Drive is only high on the take edge, so the new kind is used before kind_q holds it
  assign cur_kind = take ? I_KIND : kind_q;
  // Idle, one strobe cycle, one recovery cycle
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (take) state_d = ST_ACCESS;
      ST_ACCESS: state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      state_q <= ST_IDLE;
      kind_q <= ACC_NONE;
      busy_q <= 1'b0;
    end
    else if (I_CE)
    begin
      state_q <= state_d;
      busy_q <= state_d != ST_IDLE;
      if (take)
        kind_q <= I_KIND;
    end
  end
  // Pin drive; the acknowledge cycle needs no chip select
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      ds_q <= `HP_OD_RELEASE;
      cs_q <= `HP_OD_RELEASE;
      rw_q <= `HP_OD_RELEASE;
      ack_q <= `HP_OD_RELEASE;
      srv_q <= 1'b0;
      rx_q <= 1'b0;
    end
    else if (I_CE)
    begin
      cs_q <= !(drive && cur_kind != ACC_IACK); // RQ3
      if (I_BUS_MODE == `HP_MODE_SINGLE)
      begin
        ds_q <= !(drive && cur_kind != ACC_IACK); // RQ1
        rw_q <= !(drive && cur_kind == ACC_WRITE); // RQ11
      end
      else
      begin
        ds_q <= !(drive && cur_kind == ACC_WRITE); // RQ2
        rw_q <= !(drive && cur_kind == ACC_READ); // RQ12
      end
      ack_q <= !(drive && I_REQ_MODE == `HP_REQ_MODE0 && cur_kind == ACC_IACK); // RQ7 RQ8
      srv_q <= BUS.pin_level[`HP_PIN_REQ] == `HP_OD_ASSERT; // RQ13
      rx_q <= I_REQ_MODE == `HP_REQ_MODE1 && BUS.pin_level[`HP_PIN_ACK] == `HP_OD_ASSERT; // RQ6
    end
  end
  assign BUS.host_data_strobe = ds_q;
  assign BUS.host_port_select = cs_q;
  assign BUS.host_read_write_dir = rw_q;
  assign BUS.host_acknowledge_in = ack_q;
  assign O_BUSY = busy_q;
  assign O_SERVICE_REQ = srv_q;
  assign O_RX_REQ = rx_q;
endmodule

// *** verification/host_port_props.sv ***
`timescale 1ns/100ps
module host_port_props
(
  input wire logic I_CLK, // Clock
  input wire logic I_RESET_N, // Reset, low
  input wire logic I_PORT_SEL, // Port on
  input wire logic I_REQ_MODE, // Request mode
  input wire logic I_TX_REQ, // Tx want
  input wire logic I_RX_REQ, // Rx want
  input wire logic req_pin_out, // Req value
  input wire logic req_pin_oe, // Req pull
  input wire logic ack_pin_out, // Ack value
  input wire logic ack_pin_oe, // Ack pull
  input wire logic host_data_strobe, // Strobe
  input wire logic host_port_select // Select
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Three settled edges cover the one-cycle lag and the isolated edge after reset
  wire m0 = I_PORT_SEL && !I_REQ_MODE;
  wire m1 = I_PORT_SEL && I_REQ_MODE;
  a_open_drain:
    assert property (!req_pin_out && !ack_pin_out) else $error("Open drain pin driven high");
  a_reset_iso:
    assert property ($rose(I_RESET_N) |-> !req_pin_oe && !ack_pin_oe) else $error("Pin driven after reset");
  a_m0_request:
    assert property ((m0 && (I_TX_REQ || I_RX_REQ))[*3] |-> req_pin_oe) else $error("Service request missing");
  a_m0_idle:
    assert property ((m0 && !I_TX_REQ && !I_RX_REQ)[*3] |-> !req_pin_oe) else $error("Spurious request");
  a_m1_tx:
    assert property ((m1 && I_TX_REQ)[*3] |-> req_pin_oe) else $error("Tx request missing");
  a_m1_rx:
    assert property ((m1 && I_RX_REQ)[*3] |-> ack_pin_oe) else $error("Rx request missing");
  a_m0_ack_in:
    assert property ((m0)[*3] |-> !ack_pin_oe) else $error("Ack pin driven in mode 0");
  a_unsel_quiet:
    assert property ((!I_PORT_SEL)[*3] |-> !req_pin_oe && !ack_pin_oe) else $error("Request while unselected");
  a_strobe_cs:
    assert property (!host_data_strobe |-> !host_port_select) else $error("Strobe without select");
endmodule

// *** verification/test_host_port_pin_control.sv ***
`timescale 1ns/100ps
module test_host_port_pin_control;
  import host_port_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, sel = 1'b1, bm = 1'b0, rm = 1'b0, tx = 1'b0, rx = 1'b0, start = 1'b0;
  access_kind_type kind = ACC_NONE;
  logic [4:0] gout = 5'h00, gdir = 5'h00, gin;
  logic rd, wr, iack, busy, sreq, rreq;
  logic cs_hold = 1'b0;
  int mismatches = 0, tests_run = 0;
  host_port_if bus();
  always #12.5 clk = ~clk;
  // Device drive wins; open drain pulls low; request line has a pull-up
  assign bus.pin_level[0] = bus.gpio_dev_oe[0] ? bus.gpio_dev_out[0] : bus.host_data_strobe;
  // A gate on the host side can hold chip select high while the strobes still move
  assign bus.pin_level[1] = bus.gpio_dev_oe[1] ? bus.gpio_dev_out[1] : (bus.host_port_select | cs_hold);
  assign bus.pin_level[2] = bus.req_pin_oe ? 1'b0 : (bus.gpio_dev_oe[2] ? bus.gpio_dev_out[2] : 1'b1);
  assign bus.pin_level[3] = bus.ack_pin_oe ? 1'b0 : (bus.gpio_dev_oe[3] ? bus.gpio_dev_out[3] : bus.host_acknowledge_in);
  assign bus.pin_level[4] = bus.gpio_dev_oe[4] ? bus.gpio_dev_out[4] : bus.host_read_write_dir;
  host_port_device i_host_port_device (.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(1'b1), .BUS(bus.device),
    .I_PORT_SEL(sel), .I_BUS_MODE(bm), .I_REQ_MODE(rm), .I_TX_REQ(tx), .I_RX_REQ(rx), .I_GPIO_OUT(gout),
    .I_GPIO_DIR(gdir), .O_GPIO_IN(gin), .O_RD_PULSE(rd), .O_WR_PULSE(wr), .O_IACK_PULSE(iack));
  host_port_host i_host_port_host (.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(1'b1), .BUS(bus.host), .I_BUS_MODE(bm),
    .I_REQ_MODE(rm), .I_START(start), .I_KIND(kind), .O_BUSY(busy), .O_SERVICE_REQ(sreq), .O_RX_REQ(rreq));
  host_port_props i_host_port_props (.I_CLK(clk), .I_RESET_N(rst_n), .I_PORT_SEL(sel), .I_REQ_MODE(rm),
    .I_TX_REQ(tx), .I_RX_REQ(rx), .req_pin_out(bus.req_pin_out), .req_pin_oe(bus.req_pin_oe),
    .ack_pin_out(bus.ack_pin_out), .ack_pin_oe(bus.ack_pin_oe), .host_data_strobe(bus.host_data_strobe),
    .host_port_select(bus.host_port_select));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pulse counts packed as rd, wr, iack in two bits each
  task access(input access_kind_type k, input logic [7:0] exp);
    logic [7:0] seen;
    seen = 8'h00;
    @(negedge clk);
    kind = k;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk({7'h00, busy}, 8'h01);
    repeat (7)
    begin
      @(negedge clk);
      seen = seen + {3'h0, rd, 1'b0, wr, 1'b0, iack};
    end
    chk(seen, exp);
  endtask
  task reqs(input logic t, input logic r, input logic [7:0] exp);
    @(negedge clk);
    tx = t;
    rx = r;
    repeat (4) @(negedge clk);
    chk({6'h00, sreq, rreq}, exp);
  endtask
  task t_reset;
    tx = 1'b1;
    repeat (16) @(negedge clk);
    chk({7'h00, bus.req_pin_oe}, 8'h00);
    rst_n = 1'b1;
    tx = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task t_access;
    access(ACC_READ, 8'h10);
    access(ACC_WRITE, 8'h04);
    access(ACC_IACK, 8'h01);
    bm = 1'b1;
    access(ACC_READ, 8'h10);
    access(ACC_WRITE, 8'h04);
    sel = 1'b0;
    access(ACC_WRITE, 8'h00);
    sel = 1'b1;
    cs_hold = 1'b1;
    access(ACC_WRITE, 8'h00);
    cs_hold = 1'b0;
  endtask
  // Second reset in mid-run: requests stay released and the first edge after it is isolated
  task t_midreset;
    @(negedge clk);
    rst_n = 1'b0;
    tx = 1'b1;
    repeat (3) @(negedge clk);
    chk({6'h00, bus.req_pin_oe, bus.ack_pin_oe}, 8'h00);
    rst_n = 1'b1;
    @(negedge clk);
    chk({6'h00, bus.req_pin_oe, sreq}, 8'h00);
    tx = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task t_requests;
    reqs(1'b1, 1'b0, 8'h02);
    reqs(1'b0, 1'b1, 8'h02);
    reqs(1'b0, 1'b0, 8'h00);
    rm = 1'b1;
    reqs(1'b1, 1'b0, 8'h02);
    reqs(1'b0, 1'b1, 8'h01);
    access(ACC_IACK, 8'h00);
    reqs(1'b0, 1'b0, 8'h00);
  endtask
  task t_gpio;
    @(negedge clk);
    sel = 1'b0;
    gdir = 5'h1f;
    gout = 5'h15;
    repeat (5) @(negedge clk);
    chk({3'h0, gin}, 8'h15);
    gdir = 5'h00;
    repeat (5) @(negedge clk);
    chk({3'h0, gin}, 8'h1f);
  endtask
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    t_reset();
    t_access();
    t_requests();
    t_midreset();
    t_gpio();
    report_and_stop();
  end
  // About 138 cycles expected; the 2000-cycle limit, over fourteen times that, means a hang
  initial
  begin
    #(2000 * 25);
    mismatches++;
    report_and_stop();
  end
endmodule
